// file: core/shutdown_comparator.sv
// Purpose: Threshold comparator with hysteresis for one temperature channel.
// Assumes: Measurement, threshold and hysteresis are unsigned whole degrees.
// Notes: Apart from synchronous reset, which clears it, the flag only moves on a measurement strobe.
`timescale 1ns/100ps
module shutdown_comparator (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Measurement
	input wire logic meas_valid,
	input wire logic [7:0] meas,
	// Limits
	input wire logic [7:0] threshold,
	input wire logic [7:0] hysteresis,
	// Result
	output logic shutdown_q
);

	logic shutdown_d;
	logic [8:0] meas_plus_hyst;

	// ==========================================================
	// Next state
	// Releasing on meas + hysteresis < threshold avoids a negative bound.
	always_comb begin
		meas_plus_hyst = {1'b0, meas} + {1'b0, hysteresis};
		shutdown_d = shutdown_q;
		if (meas_valid) begin
			if (meas > threshold) begin
				shutdown_d = 1'b1; // RULE12
			end else if (meas_plus_hyst < {1'b0, threshold}) begin
				shutdown_d = 1'b0; // RULE12
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			shutdown_q <= 1'b0;
		end else begin
			shutdown_q <= shutdown_d;
		end
	end

	// ==========================================================
	// Checks
	AST_TRIP: assert property (@(posedge clk) disable iff (srst) // RULE12
		meas_valid && (meas > threshold) |=> shutdown_q)
		else $error("shutdown did not trip above threshold");

	AST_HOLD_IN_BAND: assert property (@(posedge clk) disable iff (srst) // RULE12
		shutdown_q && meas_valid
		&& ({1'b0, meas} + {1'b0, hysteresis} >= {1'b0, threshold})
		|=> shutdown_q)
		else $error("shutdown released inside hysteresis band");

	AST_QUIET: assert property (@(posedge clk) disable iff (srst) // RULE12
		!meas_valid |=> $stable(shutdown_q))
		else $error("shutdown moved without a measurement");

endmodule : shutdown_comparator

// file: core/temp_limit_pkg.sv
// Purpose: Constants for the limit, result and shutdown register slice.
// Assumes: Pointer values are byte addresses on the serial register port.
// Notes: Summary of operation follows.
// Summary of operation
// RULE1 - Pointer 13h is a read/write byte whose bits 7..4 are the remote high limit fraction.
// RULE2 - Pointer 14h is a read/write byte whose upper nibble is the remote low limit fraction, reset to zero.
// RULE3 - Pointer 15h is a read-only byte whose upper nibble is the local result fraction and writes to it are dropped.
// RULE4 - Each completed conversion refreshes the local low byte unless the byte pair lock holds it.
// RULE5 - Reading the high byte first freezes the low byte until the low byte is read.
// RULE6 - Reading the low byte first freezes the high byte until the high byte is read.
// RULE7 - Reading any other register releases the byte pair lock.
// RULE8 - The host should read the high byte first and the low byte in the very next read.
// RULE9 - Pointer 19h holds the remote shutdown threshold in whole degrees, reset 6Ch.
// RULE10 - Pointer 20h holds the local shutdown threshold in whole degrees, reset 55h.
// RULE11 - Pointer 21h holds the shutdown hysteresis in whole degrees, reset 0Ah.
// RULE12 - Shutdown asserts when a measurement exceeds its threshold and clears only below threshold minus hysteresis.
package temp_limit_pkg;

	// ==========================================================
	// Register pointers
	localparam logic [7:0] PTR_LOCAL_HIGH = 8'h00;
	localparam logic [7:0] PTR_REMOTE_HIGH_FRAC = 8'h13;
	localparam logic [7:0] PTR_REMOTE_LOW_FRAC = 8'h14;
	localparam logic [7:0] PTR_LOCAL_FRAC = 8'h15;
	localparam logic [7:0] PTR_REMOTE_THR = 8'h19;
	localparam logic [7:0] PTR_LOCAL_THR = 8'h20;
	localparam logic [7:0] PTR_HYST = 8'h21;

	// ==========================================================
	// Field positions and reset values
	localparam int FRAC_MSB = 7;
	localparam int FRAC_LSB = 4;
	localparam logic [3:0] RST_FRAC = 4'h0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_REMOTE_THR = 8'h6c;
	localparam logic [7:0] RST_LOCAL_THR = 8'h55;
	localparam logic [7:0] RST_HYST = 8'h0a;

	// ==========================================================
	// Byte pair lock states
	typedef enum logic [1:0] {
		LOCK_NONE = 2'b00,
		LOCK_LOW_HELD = 2'b01,
		LOCK_HIGH_HELD = 2'b10
	} lock_e;

endpackage : temp_limit_pkg

// file: core/temp_limit_result_regs.sv
// Purpose: Limit, local result and shutdown registers behind the pointer port.
// Assumes: Register port and conversion strobes are on the clk domain.
// Notes: Read data is registered and valid the cycle after reg_rd.
`timescale 1ns/100ps
module temp_limit_result_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Pointer register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Conversion engine
	input wire logic local_conv_done,
	input wire logic [7:0] local_result_high,
	input wire logic [7:0] local_result_low,
	input wire logic remote_conv_done,
	input wire logic [7:0] remote_result_high,
	// Limit outputs to the remote comparator
	output logic [3:0] remote_high_limit_frac_bits,
	output logic [3:0] remote_low_limit_frac_bits,
	// Shutdown outputs
	output logic over_temp_shutdown_remote,
	output logic over_temp_shutdown_local,
	output logic over_temp_shutdown
);

	logic [3:0] rhl_frac_q, rhl_frac_d;
	logic [3:0] rll_frac_q, rll_frac_d;
	logic [7:0] local_high_q, local_high_d;
	logic [3:0] local_result_frac_bits_q, local_frac_d;
	logic [7:0] remote_shutdown_threshold_bits_q, rthr_d;
	logic [7:0] local_shutdown_threshold_bits_q, lthr_d;
	logic [7:0] shutdown_hysteresis_bits_q, hyst_d;
	logic [7:0] rdata_q, rdata_d;
	logic any_shutdown_q, any_shutdown_d;
	temp_limit_pkg::lock_e lock_q, lock_d;
	logic rd_high, rd_low;

	// ==========================================================
	// Byte pair lock
	assign rd_high = reg_rd && (reg_addr == temp_limit_pkg::PTR_LOCAL_HIGH);
	assign rd_low = reg_rd && (reg_addr == temp_limit_pkg::PTR_LOCAL_FRAC);

	always_comb begin
		lock_d = lock_q;
		if (rd_high) begin
			if (lock_q == temp_limit_pkg::LOCK_HIGH_HELD) begin
				lock_d = temp_limit_pkg::LOCK_NONE; // RULE6
			end else begin
				lock_d = temp_limit_pkg::LOCK_LOW_HELD; // RULE5
			end
		end else if (rd_low) begin
			if (lock_q == temp_limit_pkg::LOCK_LOW_HELD) begin
				lock_d = temp_limit_pkg::LOCK_NONE; // RULE5
			end else begin
				lock_d = temp_limit_pkg::LOCK_HIGH_HELD; // RULE6
			end
		end else if (reg_rd) begin
			lock_d = temp_limit_pkg::LOCK_NONE; // RULE7
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			lock_q <= temp_limit_pkg::LOCK_NONE;
		end else begin
			lock_q <= lock_d;
		end
	end

	// ==========================================================
	// Result bytes
	// A byte is held when the lock holds it now or will after this read,
	// so a conversion landing on the first read cannot split the pair.
	always_comb begin
		local_high_d = local_high_q;
		local_frac_d = local_result_frac_bits_q;
		if (local_conv_done) begin
			if (lock_q != temp_limit_pkg::LOCK_HIGH_HELD
				&& lock_d != temp_limit_pkg::LOCK_HIGH_HELD) begin
				local_high_d = local_result_high; // RULE6
			end
			if (lock_q != temp_limit_pkg::LOCK_LOW_HELD
				&& lock_d != temp_limit_pkg::LOCK_LOW_HELD) begin
				local_frac_d = local_result_low[temp_limit_pkg::FRAC_MSB:
					temp_limit_pkg::FRAC_LSB]; // RULE4
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			local_high_q <= temp_limit_pkg::RST_BYTE;
			local_result_frac_bits_q <= temp_limit_pkg::RST_FRAC;
		end else begin
			local_high_q <= local_high_d;
			local_result_frac_bits_q <= local_frac_d;
		end
	end

	// ==========================================================
	// Writable registers
	// Pointer 15h has no write target, so a write there falls through.
	always_comb begin
		rhl_frac_d = rhl_frac_q;
		rll_frac_d = rll_frac_q;
		rthr_d = remote_shutdown_threshold_bits_q;
		lthr_d = local_shutdown_threshold_bits_q;
		hyst_d = shutdown_hysteresis_bits_q;
		if (reg_wr) begin
			if (reg_addr == temp_limit_pkg::PTR_REMOTE_HIGH_FRAC) begin
				rhl_frac_d = reg_wdata[temp_limit_pkg::FRAC_MSB:
					temp_limit_pkg::FRAC_LSB]; // RULE1
			end else if (reg_addr == temp_limit_pkg::PTR_REMOTE_LOW_FRAC) begin
				rll_frac_d = reg_wdata[temp_limit_pkg::FRAC_MSB:
					temp_limit_pkg::FRAC_LSB]; // RULE2
			end else if (reg_addr == temp_limit_pkg::PTR_REMOTE_THR) begin
				rthr_d = reg_wdata; // RULE9
			end else if (reg_addr == temp_limit_pkg::PTR_LOCAL_THR) begin
				lthr_d = reg_wdata; // RULE10
			end else if (reg_addr == temp_limit_pkg::PTR_HYST) begin
				hyst_d = reg_wdata; // RULE11
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rhl_frac_q <= temp_limit_pkg::RST_FRAC;
			rll_frac_q <= temp_limit_pkg::RST_FRAC;
			remote_shutdown_threshold_bits_q <= temp_limit_pkg::RST_REMOTE_THR;
			local_shutdown_threshold_bits_q <= temp_limit_pkg::RST_LOCAL_THR;
			shutdown_hysteresis_bits_q <= temp_limit_pkg::RST_HYST;
		end else begin
			rhl_frac_q <= rhl_frac_d;
			rll_frac_q <= rll_frac_d;
			remote_shutdown_threshold_bits_q <= rthr_d;
			local_shutdown_threshold_bits_q <= lthr_d;
			shutdown_hysteresis_bits_q <= hyst_d;
		end
	end

	// ==========================================================
	// Read data
	// Reserved low nibbles read as zero; unmapped pointers read 00h.
	always_comb begin
		rdata_d = rdata_q;
		if (reg_rd) begin
			if (reg_addr == temp_limit_pkg::PTR_LOCAL_HIGH) begin
				rdata_d = local_high_q;
			end else if (reg_addr == temp_limit_pkg::PTR_REMOTE_HIGH_FRAC) begin
				rdata_d = {rhl_frac_q, 4'h0}; // RULE1
			end else if (reg_addr == temp_limit_pkg::PTR_REMOTE_LOW_FRAC) begin
				rdata_d = {rll_frac_q, 4'h0}; // RULE2
			end else if (reg_addr == temp_limit_pkg::PTR_LOCAL_FRAC) begin
				rdata_d = {local_result_frac_bits_q, 4'h0}; // RULE3
			end else if (reg_addr == temp_limit_pkg::PTR_REMOTE_THR) begin
				rdata_d = remote_shutdown_threshold_bits_q;
			end else if (reg_addr == temp_limit_pkg::PTR_LOCAL_THR) begin
				rdata_d = local_shutdown_threshold_bits_q;
			end else if (reg_addr == temp_limit_pkg::PTR_HYST) begin
				rdata_d = shutdown_hysteresis_bits_q;
			end else begin
				rdata_d = temp_limit_pkg::RST_BYTE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_q <= temp_limit_pkg::RST_BYTE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ==========================================================
	// Shutdown comparators
	shutdown_comparator u_remote_cmp (
		.clk(clk),
		.srst(srst),
		.meas_valid(remote_conv_done),
		.meas(remote_result_high),
		.threshold(remote_shutdown_threshold_bits_q),
		.hysteresis(shutdown_hysteresis_bits_q),
		.shutdown_q(over_temp_shutdown_remote)
	);

	shutdown_comparator u_local_cmp (
		.clk(clk),
		.srst(srst),
		.meas_valid(local_conv_done),
		.meas(local_result_high),
		.threshold(local_shutdown_threshold_bits_q),
		.hysteresis(shutdown_hysteresis_bits_q),
		.shutdown_q(over_temp_shutdown_local)
	);

	// The combined pin is one cycle behind the channel flags.
	always_comb begin
		any_shutdown_d = over_temp_shutdown_remote | over_temp_shutdown_local;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			any_shutdown_q <= 1'b0;
		end else begin
			any_shutdown_q <= any_shutdown_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign remote_high_limit_frac_bits = rhl_frac_q;
	assign remote_low_limit_frac_bits = rll_frac_q;
	assign over_temp_shutdown = any_shutdown_q;

	// ==========================================================
	// Checks
	AST_HIGH_FRAC_WR: assert property (@(posedge clk) disable iff (srst) // RULE1
		reg_wr && reg_addr == 8'h13 |=> rhl_frac_q == $past(reg_wdata[7:4]))
		else $error("high limit fraction write lost");

	AST_LOW_FRAC_WR: assert property (@(posedge clk) disable iff (srst) // RULE2
		reg_wr && reg_addr == 8'h14 |=> rll_frac_q == $past(reg_wdata[7:4]))
		else $error("low limit fraction write lost");

	AST_LOCAL_RO: assert property (@(posedge clk) disable iff (srst) // RULE3
		reg_wr && reg_addr == 8'h15 && !local_conv_done
		|=> $stable(local_result_frac_bits_q))
		else $error("write changed the local fraction");

	AST_CONV_REFRESH: assert property (@(posedge clk) disable iff (srst) // RULE4
		local_conv_done && lock_q == temp_limit_pkg::LOCK_NONE && !reg_rd
		|=> local_result_frac_bits_q == $past(local_result_low[7:4]))
		else $error("conversion did not refresh the local fraction");

	AST_LOW_HELD: assert property (@(posedge clk) disable iff (srst) // RULE5
		rd_high && lock_q != temp_limit_pkg::LOCK_HIGH_HELD
		##1 (!reg_rd)[*2] |=> $stable(local_result_frac_bits_q))
		else $error("low byte changed while locked");

	AST_HIGH_HELD: assert property (@(posedge clk) disable iff (srst) // RULE6
		rd_low && local_conv_done
		&& lock_q != temp_limit_pkg::LOCK_LOW_HELD
		|=> local_high_q == $past(local_high_q))
		else $error("high byte changed while locked");

	AST_RELEASE: assert property (@(posedge clk) disable iff (srst) // RULE7
		reg_rd && !rd_high && !rd_low |=> lock_q == temp_limit_pkg::LOCK_NONE)
		else $error("lock survived a read of another register");

	AST_THR_READ: assert property (@(posedge clk) disable iff (srst) // RULE9
		reg_rd && reg_addr == 8'h19
		|=> reg_rdata == $past(remote_shutdown_threshold_bits_q))
		else $error("remote threshold read mismatch");

	AST_LOCAL_THR_WR: assert property (@(posedge clk) disable iff (srst) // RULE10
		reg_wr && reg_addr == 8'h20
		|=> local_shutdown_threshold_bits_q == $past(reg_wdata))
		else $error("local threshold write lost");

	AST_HYS_WR: assert property (@(posedge clk) disable iff (srst) // RULE11
		reg_wr && reg_addr == 8'h21
		|=> shutdown_hysteresis_bits_q == $past(reg_wdata))
		else $error("hysteresis write lost");

endmodule : temp_limit_result_regs

// file: tb/host_port_model.sv
// Purpose: Host controller side of the pointer register port.
// Assumes: Requests launch on a rising edge and last one cycle.
// Notes: Released address and data lines show the inverse of the last value.
`timescale 1ns/100ps
module host_port_model (
	// Clock
	input wire logic clk,
	// Register port
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// ==========================================================
	// Requests
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= addr;
		reg_wdata <= data;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~addr;
		reg_wdata <= ~data;
	endtask : write_reg

	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= addr;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~addr;
		#1;
		data = reg_rdata;
	endtask : read_reg

	// The high byte goes first and the low byte in the very next read.
	task automatic read_pair(output logic [7:0] high, output logic [7:0] low);
		read_reg(temp_limit_pkg::PTR_LOCAL_HIGH, high);
		read_reg(temp_limit_pkg::PTR_LOCAL_FRAC, low);
	endtask : read_pair
endmodule : host_port_model

// file: tb/temp_limit_result_regs_tb.sv
// Purpose: Self-checking bench for the limit, result and shutdown registers.
// Assumes: Read data and channel flags settle one cycle after their strobe, the combined flag one cycle later.
// Notes: Thresholds are rewritten before the shutdown sequences.
`timescale 1ns/100ps
module temp_limit_result_regs_tb;
	logic clk;
	logic srst;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic local_conv_done;
	logic [7:0] local_result_high;
	logic [7:0] local_result_low;
	logic remote_conv_done;
	logic [7:0] remote_result_high;
	logic [3:0] rh_frac;
	logic [3:0] rl_frac;
	logic sd_remote;
	logic sd_local;
	logic sd_any;
	logic [7:0] rd;
	logic [7:0] hi;
	logic exp_loc;
	logic exp_rem;
	int fails;
	int samples_checked;
	localparam logic [7:0] ad [7] = '{8'h13, 8'h14, 8'h15, 8'h19, 8'h20,
		8'h21, 8'h30};
	localparam logic [7:0] rs [7] = '{8'h00, 8'h00, 8'h00, 8'h6c, 8'h55,
		8'h0a, 8'h00};
	localparam logic [7:0] wr [7] = '{8'ha5, 8'h5f, 8'hff, 8'h40, 8'h57,
		8'h05, 8'hff};
	localparam logic [7:0] bk [7] = '{8'ha0, 8'h50, 8'h00, 8'h40, 8'h57,
		8'h05, 8'h00};

	always #4 clk = ~clk;

	host_port_model u_host_port_model (.clk(clk), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata));

	temp_limit_result_regs u_temp_limit_result_regs (.clk(clk), .srst(srst),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.local_conv_done(local_conv_done),
		.local_result_high(local_result_high),
		.local_result_low(local_result_low),
		.remote_conv_done(remote_conv_done),
		.remote_result_high(remote_result_high),
		.remote_high_limit_frac_bits(rh_frac),
		.remote_low_limit_frac_bits(rl_frac),
		.over_temp_shutdown_remote(sd_remote),
		.over_temp_shutdown_local(sd_local), .over_temp_shutdown(sd_any));

	// ==========================================================
	// Compare and stimulus tasks
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_byte

	task automatic check_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_bit

	task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp);
		u_host_port_model.read_reg(addr, rd);
		check_byte(rd, exp);
	endtask : expect_reg

	task automatic convert(input logic rem, input logic [7:0] h,
		input logic [7:0] l);
		@(posedge clk);
		local_conv_done <= !rem;
		remote_conv_done <= rem;
		local_result_high <= h;
		local_result_low <= l;
		remote_result_high <= h;
		@(posedge clk);
		local_conv_done <= 1'b0;
		remote_conv_done <= 1'b0;
		local_result_high <= ~h;
		local_result_low <= ~l;
		remote_result_high <= ~h;
		#1;
	endtask : convert

	task automatic trip(input logic rem, input logic [7:0] m, input logic e);
		convert(rem, m, 8'h00);
		if (rem) exp_rem = e;
		else exp_loc = e;
		check_bit(sd_remote, exp_rem);
		check_bit(sd_local, exp_loc);
		@(posedge clk);
		#1;
		check_bit(sd_any, exp_loc | exp_rem);
	endtask : trip

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		end_of_test();
	end

	// ==========================================================
	// Main sequence
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		local_conv_done = 1'b0;
		remote_conv_done = 1'b0;
		local_result_high = 8'h00;
		local_result_low = 8'h00;
		remote_result_high = 8'h00;
		exp_loc = 1'b0;
		exp_rem = 1'b0;
		fails = 0;
		samples_checked = 0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		check_byte({rh_frac, rl_frac}, 8'h00);
		for (int i = 0; i < 7; i++) begin
			expect_reg(ad[i], rs[i]);
		end
		$display("test reset_values done");
		for (int i = 0; i < 7; i++) begin
			u_host_port_model.write_reg(ad[i], wr[i]);
			expect_reg(ad[i], bk[i]);
		end
		check_byte({rh_frac, rl_frac}, 8'ha5);
		$display("test write_readback done");
		trip(1'b0, 8'h57, 1'b0);
		trip(1'b0, 8'h58, 1'b1);
		trip(1'b0, 8'h52, 1'b1);
		trip(1'b0, 8'h51, 1'b0);
		trip(1'b1, 8'h41, 1'b1);
		trip(1'b1, 8'h3b, 1'b1);
		trip(1'b1, 8'h3a, 1'b0);
		$display("test shutdown done");
		convert(1'b0, 8'h31, 8'ha0);
		expect_reg(8'h00, 8'h31);
		convert(1'b0, 8'h32, 8'hb0);
		expect_reg(8'h15, 8'ha0);
		expect_reg(8'h15, 8'ha0);
		convert(1'b0, 8'h33, 8'hc0);
		expect_reg(8'h00, 8'h32);
		expect_reg(8'h00, 8'h32);
		expect_reg(8'h19, 8'h40);
		convert(1'b0, 8'h34, 8'hd0);
		u_host_port_model.read_pair(hi, rd);
		check_byte(hi, 8'h34);
		check_byte(rd, 8'hd0);
		expect_reg(8'h00, 8'h34);
		expect_reg(8'h19, 8'h40);
		convert(1'b0, 8'h35, 8'he0);
		expect_reg(8'h15, 8'he0);
		expect_reg(8'h00, 8'h35);
		fork
			convert(1'b0, 8'h36, 8'hf0);
			expect_reg(8'h15, 8'he0);
		join
		expect_reg(8'h00, 8'h35);
		$display("test byte_pair_lock done");
		trip(1'b0, 8'h58, 1'b1);
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		exp_loc = 1'b0;
		#1;
		check_bit(sd_local, exp_loc);
		check_bit(sd_any, 1'b0);
		check_byte({rh_frac, rl_frac}, 8'h00);
		for (int i = 0; i < 7; i++) begin
			expect_reg(ad[i], rs[i]);
		end
		$display("test mid_reset done");
		end_of_test();
	end
endmodule : temp_limit_result_regs_tb
